// *** verilog/chc_control.v ***
// Card host port control signals: interrupt, space select, DMA ack, reset, ready
`include "chc_defines.vh"
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1: Disk-drive mode interrupt request is active high
// R2: Attribute select high common, low attribute
// R3: Host holds select low during I/O cycles
// R4: Host acknowledge answers request, starts DMA
// R5: Acknowledge ignored while no DMA active
// R6: Host without DMA ties acknowledge high
// R7: Card-bus modes: reset while reset pin high
// R8: Reset high from power-up gives one reset
// R9: Soft reset bit also resets device
// R10: Disk-drive mode reset pin is active low
// R11: Ready low until reset function completes
// R12: Reset and acknowledge pins are synchronised
module chc_control #(
    parameter BUSY_CYCLES = `CHC_RESET_BUSY_CYC
) (
    input  wire                    clock,
    input  wire                    rst_n,
    input  wire                    clk_en,
    input  wire [`CHC_MODE_W-1:0]  interface_mode,
    input  wire                    card_reset_pin,
    input  wire                    dma_acknowledge_n,
    input  wire                    attribute_select_n,
    input  wire                    soft_reset_bit,
    input  wire                    core_interrupt,
    input  wire                    core_dma_request,
    input  wire                    core_dma_active,
    input  wire                    core_busy,
    output reg                     host_interrupt_request,
    output reg                     dma_transfer_request,
    output wire                    dma_ack_valid,
    output reg                     common_memory_select,
    output reg                     attribute_memory_select,
    output reg                     io_space_select,
    output reg                     device_reset,
    output reg                     ready
);

    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    wire [1:0] pins_sync;

    chc_sync #(
        .WIDTH     (2),
        .RESET_VAL (2'h3)
    ) u_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .async_in ({card_reset_pin, dma_acknowledge_n}),  // [R12]
        .sync_out (pins_sync)
    );

    wire reset_pin_s = pins_sync[1];
    wire dma_acknowledge_n_n_s   = pins_sync[0];
    wire disk_mode   = (interface_mode == `CHC_MODE_DISK);

    // ************************************************************
    // Reset request decode
    // ************************************************************
    // Pin level seen at power-up; in the card-bus modes a level held since then is not a reset
    // Limitation: arming survives until the next power-on reset only
    reg  armed_r;
    wire pin_asserted = disk_mode ? ~reset_pin_s : reset_pin_s;  // [R7] [R10]

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            armed_r <= 1'b0;
        end else if (clk_en) begin
            if (!pin_asserted)
                armed_r <= 1'b1;  // [R8]
        end
    end

    // In the card-bus modes the reset pin only counts once it has been seen released after power-up; disk-drive mode takes it at once
    wire pin_reset_req = pin_asserted & (armed_r | disk_mode);  // [R7] [R8] [R10]
    wire reset_req     = pin_reset_req | soft_reset_bit;         // [R9]

    // ************************************************************
    // Reset sequencing and ready
    // ************************************************************
    localparam ST_POWERUP = 2'h0;
    localparam ST_HOLD    = 2'h1;
    localparam ST_BUSY    = 2'h2;
    localparam ST_RUN     = 2'h3;

    reg [1:0]                  state_r;
    reg [1:0]                  state_nxt;
    reg [`CHC_BUSY_CNT_W-1:0]  busy_cnt_r;
    reg [`CHC_BUSY_CNT_W-1:0]  busy_cnt_nxt;

    always @* begin
        state_nxt    = state_r;
        busy_cnt_nxt = busy_cnt_r;
        case (state_r)
            ST_POWERUP: begin
                // Initial reset always runs, whatever the pin does
                state_nxt    = ST_BUSY;  // [R8]
                busy_cnt_nxt = BUSY_CYCLES[`CHC_BUSY_CNT_W-1:0];
            end
            ST_HOLD: begin
                if (!reset_req) begin
                    state_nxt    = ST_BUSY;
                    busy_cnt_nxt = BUSY_CYCLES[`CHC_BUSY_CNT_W-1:0];
                end
            end
            ST_BUSY: begin
                if (reset_req)
                    state_nxt = ST_HOLD;
                else if (busy_cnt_r <= {{(`CHC_BUSY_CNT_W-1){1'b0}}, 1'b1})
                    state_nxt = ST_RUN;
                else
                    busy_cnt_nxt = busy_cnt_r - 1'b1;
            end
            ST_RUN: begin
                if (reset_req)
                    state_nxt = ST_HOLD;  // [R7] [R9]
            end
            default: begin
                state_nxt = ST_POWERUP;
            end
        endcase
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r      <= ST_POWERUP;
            busy_cnt_r   <= {`CHC_BUSY_CNT_W{1'b0}};
            device_reset <= 1'b1;
            ready        <= 1'b0;
        end else if (clk_en) begin
            state_r      <= state_nxt;
            busy_cnt_r   <= busy_cnt_nxt;
            device_reset <= (state_nxt != ST_RUN);
            // Busy while resetting, and while the core itself is busy
            ready        <= (state_nxt == ST_RUN) & ~core_busy;  // [R11]
        end
    end

    wire running = (state_r == ST_RUN);

    // ************************************************************
    // DMA acknowledge qualification
    // ************************************************************
    // Acknowledge is masked unless a DMA is in progress, so a float is harmless
    // Combinational on purpose: the pin already carries two flops of delay
    assign dma_ack_valid = running & disk_mode & core_dma_active & ~dma_acknowledge_n_n_s;  // [R4] [R5]

    // ************************************************************
    // Interrupt, DMA request and space select next values
    // ************************************************************
    wire memory_mode = (interface_mode == `CHC_MODE_MEMORY);
    wire io_mode     = (interface_mode == `CHC_MODE_IO);

    reg irq_nxt;
    reg dma_req_nxt;
    reg common_sel_nxt;
    reg attr_sel_nxt;
    reg io_sel_nxt;

    // Everything toward the host stays quiet until the busy period ends
    always @* begin
        irq_nxt        = 1'b0;
        dma_req_nxt    = 1'b0;
        common_sel_nxt = 1'b0;
        attr_sel_nxt   = 1'b0;
        io_sel_nxt     = 1'b0;
        if (running) begin
            if (disk_mode) begin
                // Interrupt and request exist only in the disk-drive mode
                irq_nxt     = core_interrupt;    // [R1]
                dma_req_nxt = core_dma_request;
            end else begin
                // Select is level-valid within the host cycle, so no synchroniser
                common_sel_nxt = memory_mode & attribute_select_n;  // [R2]
                attr_sel_nxt   = ~attribute_select_n;               // [R2]
                io_sel_nxt     = io_mode & ~attribute_select_n;     // [R3]
            end
        end
    end

    // ************************************************************
    // Output registers
    // ************************************************************
    // Registered so the host never sees a glitch from the decode above
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            host_interrupt_request  <= 1'b0;
            dma_transfer_request    <= 1'b0;
            common_memory_select    <= 1'b0;
            attribute_memory_select <= 1'b0;
            io_space_select         <= 1'b0;
        end else if (clk_en) begin
            host_interrupt_request  <= irq_nxt;         // [R1]
            dma_transfer_request    <= dma_req_nxt;
            common_memory_select    <= common_sel_nxt;  // [R2]
            attribute_memory_select <= attr_sel_nxt;    // [R2]
            io_space_select         <= io_sel_nxt;      // [R3]
        end
    end

endmodule

`default_nettype wire

// *** verilog/chc_defines.vh ***
// Constants for the card host control-signal block
`ifndef CHC_DEFINES_VH
`define CHC_DEFINES_VH

// Interface modes
`define CHC_MODE_W          2
`define CHC_MODE_MEMORY     2'h0
`define CHC_MODE_IO         2'h1
`define CHC_MODE_DISK       2'h2

// Busy time after any reset, in clock cycles
`define CHC_RESET_BUSY_CYC  16'h0040
`define CHC_BUSY_CNT_W      16

// Synchroniser depth
`define CHC_SYNC_STAGES     2

`endif

// *** verilog/chc_sync.v ***
// Two-flop synchroniser for asynchronous host pins
`timescale 1ns/1ps
`default_nettype none

module chc_sync #(
    parameter WIDTH     = 2,
    parameter RESET_VAL = 2'h0
) (
    input  wire             clock,
    input  wire             rst_n,
    input  wire             clk_en,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_r;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_r   <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else if (clk_en) begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

`default_nettype wire

// *** dv/chc_host_model.sv ***
// Host-side model driving the acknowledge and space-select pins
`timescale 1ns/1ps
`default_nettype none
module chc_host_model (
    input  wire logic clock,
    input  wire logic dma_transfer_request,
    input  wire logic use_dma,
    input  wire logic stray,
    input  wire logic io_cycle,
    input  wire logic sel_cmd,
    output var  logic dma_acknowledge_n = 1'b1,
    output var  logic attribute_select_n = 1'b1
);
    // Stray lets the acknowledge wander while the card runs no DMA
    always @(negedge clock) begin
        dma_acknowledge_n <= !(use_dma && (dma_transfer_request || stray));
        attribute_select_n <= io_cycle ? 1'b0 : sel_cmd;
    end
endmodule
`default_nettype wire

// *** dv/chc_control_sva.sv ***
// Assertion checker bound to the control-signal block
`timescale 1ns/1ps
`default_nettype none
module chc_control_sva (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       clk_en,
    input wire logic [1:0] interface_mode,
    input wire logic       card_reset_pin,
    input wire logic       attribute_select_n,
    input wire logic       soft_reset_bit,
    input wire logic       core_interrupt,
    input wire logic       core_dma_active,
    input wire logic       host_interrupt_request,
    input wire logic       dma_ack_valid,
    input wire logic       common_memory_select,
    input wire logic       attribute_memory_select,
    input wire logic       device_reset,
    input wire logic       ready
);
    default clocking dclk @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_irq_run;
        clk_en && !device_reset && interface_mode == 2'h2 && core_interrupt ##1 !device_reset;
    endsequence
    a_irq_gated: assert property (host_interrupt_request |-> interface_mode == 2'h2)
        else $error("irq outside disk mode");
    a_irq_follow: assert property (s_irq_run |-> host_interrupt_request)
        else $error("irq missed");
    a_common_sel: assert property (clk_en && !device_reset && interface_mode == 2'h0
        && attribute_select_n |=> common_memory_select) else $error("common select missed");
    a_attr_sel: assert property (clk_en && !device_reset && interface_mode != 2'h2
        && !attribute_select_n
        |=> attribute_memory_select) else $error("attribute select missed");
    a_ack_ignored: assert property (dma_ack_valid |-> interface_mode == 2'h2 && core_dma_active)
        else $error("ack taken without dma");
    a_busy_reset: assert property (device_reset |-> !ready)
        else $error("ready during reset");
    a_card_reset: assert property ($rose(device_reset) && $past(rst_n) && !$past(soft_reset_bit)
        && interface_mode != 2'h2 |-> $past(card_reset_pin, 3)) else $error("card reset cause");
    a_disk_reset: assert property ($rose(device_reset) && $past(rst_n) && !$past(soft_reset_bit)
        && interface_mode == 2'h2 |-> !$past(card_reset_pin, 3)) else $error("disk reset cause");
endmodule
bind chc_control chc_control_sva chk_u (.*);
`default_nettype wire

// *** dv/card_host_control_signals_tb_top.sv ***
// Self-checking bench for the control-signal block
`timescale 1ns/1ps
`default_nettype none
module card_host_control_signals_tb_top;
    logic clock = 0, rst_n = 0, card_reset_pin = 1, soft_reset_bit = 0, use_dma = 0;
    logic stray = 0, io_cycle = 0, sel_cmd = 1, prev_ack = 1, core_interrupt = 0;
    logic core_dma_request = 0, core_dma_active = 0, core_busy = 0, clk_en = 1;
    logic [1:0] interface_mode = 2'h0;
    wire dma_acknowledge_n, attribute_select_n, host_interrupt_request, dma_transfer_request;
    wire dma_ack_valid, common_memory_select, attribute_memory_select, io_space_select;
    wire device_reset, ready;
    int seed = 53, num_errors = 0, compares = 0, cyc = 0;
    logic act;
    initial forever #20 clock = ~clock;
    chc_control #(.BUSY_CYCLES(4)) dut_u (.*);
    chc_host_model host_u (.*);
    task automatic chk(input string nm, input logic e, input logic s);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %b seen %b", nm, e, s);
        end
    endtask
    task automatic report_and_stop;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Bounded wait; both pins move together at the end of a reset
    task automatic wait_rst(input logic v, input int hi);
        int n;
        n = 0;
        while (device_reset !== v && n < hi) begin
            @(negedge clock);
            n++;
        end
        chk("device_reset", v, device_reset);
        chk("ready", !v, ready);
    endtask
    // Expected values come from inputs held across the last edge
    task automatic run(input int k);
        repeat (k) begin
            @(negedge clock);
            chk("irq", interface_mode == 2'h2 && core_interrupt, host_interrupt_request);
            chk("dma_req", interface_mode == 2'h2 && core_dma_request, dma_transfer_request);
            chk("ack_valid", interface_mode == 2'h2 && core_dma_active && !prev_ack, dma_ack_valid);
            chk("common", interface_mode == 2'h0 && attribute_select_n, common_memory_select);
            chk("attr", interface_mode != 2'h2 && !attribute_select_n, attribute_memory_select);
            chk("io", interface_mode == 2'h1 && !attribute_select_n, io_space_select);
            chk("ready", !core_busy, ready);
            prev_ack = dma_acknowledge_n;
            {core_interrupt, core_dma_request, core_dma_active, core_busy} <= $random(seed);
            {sel_cmd, stray, io_cycle} <= $random(seed);
        end
        {core_interrupt, core_dma_request, core_dma_active, core_busy, stray, io_cycle} <= 6'h00;
        sel_cmd <= 1'b1;
        prev_ack = 1'b1;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc > 3000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        for (int m = 0; m < 3; m++) begin
            act = (m != 2);
            interface_mode <= m[1:0];
            use_dma <= (m == 2);
            rst_n <= 1'b0;
            card_reset_pin <= 1'b1;
            repeat (3) @(negedge clock);
            rst_n <= 1'b1;
            wait_rst(1'b0, 12);
            run(60);
            // Clock enable low must freeze state, so a soft reset is not seen
            clk_en <= 1'b0;
            soft_reset_bit <= 1'b1;
            repeat (4) @(negedge clock);
            chk("frozen_reset", 1'b0, device_reset);
            clk_en <= 1'b1;
            soft_reset_bit <= 1'b0;
            repeat (3) @(negedge clock);
            card_reset_pin <= !act;
            repeat (4) @(negedge clock);
            chk("device_reset", 1'b0, device_reset);
            card_reset_pin <= act;
            wait_rst(1'b1, 6);
            card_reset_pin <= !act;
            wait_rst(1'b0, 12);
            soft_reset_bit <= 1'b1;
            wait_rst(1'b1, 4);
            soft_reset_bit <= 1'b0;
            wait_rst(1'b0, 12);
            run(20);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
